//--- rtl/adcrb_pkg.sv
// shared constants and carrier types of the converter control register bank
`default_nettype none
package adcrb_pkg;
    // register offsets
    localparam logic [4:0] OFS_CONTROL_A = 5'h00;
    localparam logic [4:0] OFS_CONTROL_B = 5'h01;
    localparam logic [4:0] OFS_CONTROL_C = 5'h02;
    localparam logic [4:0] OFS_CONTROL_D = 5'h03;
    localparam logic [4:0] OFS_CONTROL_E = 5'h04;
    localparam logic [4:0] OFS_SAMPLE_LEN = 5'h05;
    localparam logic [4:0] OFS_INPUT_SEL = 5'h06;
    localparam logic [4:0] OFS_COMMAND = 5'h08;
    localparam logic [4:0] OFS_EVENT_CTRL = 5'h09;
    localparam logic [4:0] OFS_IRQ_ENABLE = 5'h0A;
    localparam logic [4:0] OFS_IRQ_FLAGS = 5'h0B;
    localparam logic [4:0] OFS_DEBUG_CTRL = 5'h0C;
    localparam logic [4:0] OFS_BYTE_LATCH = 5'h0D;
    localparam logic [4:0] OFS_RESULT = 5'h10;
    localparam logic [4:0] OFS_WIN_LOW = 5'h12;
    localparam logic [4:0] OFS_WIN_HIGH = 5'h14;
    localparam logic [4:0] OFS_CALIBRATION = 5'h16;
    // writable bit masks, other bits read as zero
    localparam logic [7:0] MSK_CONTROL_A = 8'h87;
    localparam logic [7:0] MSK_CONTROL_B = 8'h07;
    localparam logic [7:0] MSK_CONTROL_C = 8'h77;
    localparam logic [7:0] MSK_CONTROL_E = 8'h07;
    localparam logic [7:0] MSK_FIVE_BIT = 8'h1F;
    localparam logic [7:0] MSK_ONE_BIT = 8'h01;
    localparam logic [7:0] MSK_TWO_BIT = 8'h03;
    // field positions
    localparam int POS_ENABLE = 0;
    localparam int POS_CONTINUOUS = 1;
    localparam int POS_RESOLUTION = 2;
    localparam int POS_STANDBY_RUN = 7;
    localparam int POS_SAMPLE_CAP = 6;
    localparam int POS_REFERENCE = 4;
    localparam int POS_FLAG_READY = 0;
    localparam int POS_FLAG_WINDOW = 1;
    // reset value of every register
    localparam logic [7:0] RST_BYTE = 8'h00;
    // window comparator modes
    localparam logic [2:0] WIN_NONE = 3'h0;
    localparam logic [2:0] WIN_BELOW = 3'h1;
    localparam logic [2:0] WIN_ABOVE = 3'h2;
    localparam logic [2:0] WIN_INSIDE = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;
    // accumulation code that is reserved
    localparam logic [2:0] ACC_RESERVED = 3'h7;

    typedef enum logic [0:0] {PH_IDLE, PH_WAIT} adcrb_phase_e;

    // register bus request from software
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcrb_bus_req_s;

    // settings handed to the analog core
    typedef struct packed {
        logic [1:0] reference_sel;
        logic sample_cap_sel;
        logic [4:0] input_select;
        logic [4:0] sample_len;
        logic [7:0] delay_ctrl;
        logic clock_duty_trim;
    } adcrb_core_cfg_s;
endpackage
`default_nettype wire

//--- rtl/adcrb_top.sv
// converter control logic and register bank
//
// Contract
// - enable bit in control A at 0 disables converter, at 1 enables it
// - writing continuous bit to 1 selects continuous conversion mode
// - continuous mode waits for software start; never starts by itself
// - continuous mode relaunches after each completion, flagged by result ready
// - resolution select 0 accumulates or stores full 10-bit samples
// - resolution select 1 keeps upper eight bits, drops two lowest
// - standby run bit decides whether converter operates during standby
// - accumulation code 0 none, 1..6 give 2 to 64 samples, 7 reserved
// - selected samples summed into result as one conversion before reporting
// - control C bit 6 selects normal or reduced sample capacitor
// - reference field: 0 internal, 1 supply, 2 external pin
// - prescaler divides peripheral clock by 2 up to 256
// - start bit reads 1 during conversion, clears itself on completion in single mode; stays set in continuous mode
// - flags cleared by writing 1 or reading result; writing 0 ignored
// - window mode raises window flag below, above, inside or outside
// - start event enabled: rising event edge sets start bit and converts
`timescale 1ns/1ps
`default_nettype none
module adcrb_top (
    input wire logic i_ref_clk,                       // peripheral clock
    input wire logic i_sys_rst,                       // synchronous reset, high
    input wire adcrb_pkg::adcrb_bus_req_s i_bus,      // register bus request
    output logic [7:0] o_rd_data,                     // read data, cycle after read
    output logic o_core_start,                        // start pulse to analog core
    input wire logic i_core_done,                     // sample done strobe
    input wire logic [9:0] i_core_sample,             // sample from analog core
    output adcrb_pkg::adcrb_core_cfg_s o_core_cfg,    // settings for analog core
    output logic o_conv_clk,                          // divided conversion clock
    output logic o_enabled,                           // enable bit of control A, stays high while standby or debug halt stops conversion
    input wire logic i_start_event,                   // asynchronous start event
    input wire logic i_standby,                       // chip in standby sleep
    input wire logic i_debug_halt,                    // cpu halted by debugger
    output logic o_result_event,                      // one-cycle result ready event
    output logic o_irq                                // level interrupt request
);

    typedef struct packed {
        logic [7:0] control_a;
        logic [7:0] control_b;
        logic [7:0] control_c;
        logic [7:0] control_d;
        logic [7:0] control_e;
        logic [7:0] sample_length_ctrl;
        logic [7:0] input_select;
        logic [7:0] event_control;
        logic [7:0] irq_enable;
        logic [7:0] irq_flags;
        logic [7:0] debug_control;
        logic [7:0] byte_latch;
        logic [7:0] calibration;
        logic [15:0] conversion_result;
        logic [15:0] window_low_threshold;
        logic [15:0] window_high_threshold;
        logic [15:0] acc;
        logic [6:0] acc_cnt;
        logic start_conversion;
        adcrb_pkg::adcrb_phase_e phase;
        logic [7:0] div_cnt;
        logic conv_clk;
        logic start_pulse;
        logic result_event;
        logic [7:0] rd_data;
        logic evt_s1;
        logic evt_s2;
        logic evt_prev;
        logic stby_s1;
        logic stby_s2;
        logic dbg_s1;
        logic dbg_s2;
    } adcrb_state_s;

    adcrb_state_s st;
    adcrb_state_s next_st;

    // number of samples summed per conversion
    function automatic logic [6:0] adcrb_acc_total(input logic [2:0] code);
        logic [6:0] total;
        total = 7'h01;
        if (code != adcrb_pkg::ACC_RESERVED) begin
            total = 7'(7'h01 << code);
        end
        return total;
    endfunction

    // window comparison on a finished result
    function automatic logic adcrb_win_hit(input logic [2:0] mode, input logic [15:0] res,
                                           input logic [15:0] lo, input logic [15:0] hi);
        logic hit;
        hit = 1'b0;
        case (mode)
            adcrb_pkg::WIN_BELOW: hit = res < lo;
            adcrb_pkg::WIN_ABOVE: hit = res > hi;
            adcrb_pkg::WIN_INSIDE: hit = (res > lo) && (res < hi);
            adcrb_pkg::WIN_OUTSIDE: hit = (res < lo) || (res > hi);
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic active;
        logic evt_rise;
        logic kick;
        logic [7:0] flag_set;
        logic [7:0] flag_clr;
        logic [15:0] sample_val;
        logic [15:0] sum;
        next_st = st;
        active = 1'b0;
        evt_rise = 1'b0;
        kick = 1'b0;
        flag_set = 8'h00;
        flag_clr = 8'h00;
        sample_val = 16'h0000;
        sum = 16'h0000;
        next_st.start_pulse = 1'b0;
        next_st.result_event = 1'b0;
        next_st.rd_data = 8'h00;

        // pin synchronisers, second stage feeds logic
        next_st.evt_s1 = i_start_event;
        next_st.evt_s2 = st.evt_s1;
        next_st.evt_prev = st.evt_s2;
        next_st.stby_s1 = i_standby;
        next_st.stby_s2 = st.stby_s1;
        next_st.dbg_s1 = i_debug_halt;
        next_st.dbg_s2 = st.dbg_s1;

        next_st.div_cnt = st.div_cnt + 8'h01;
        next_st.conv_clk = st.div_cnt[st.control_c[2:0]];

        active = st.control_a[adcrb_pkg::POS_ENABLE];
        if (st.stby_s2 && !st.control_a[adcrb_pkg::POS_STANDBY_RUN]) begin
            active = 1'b0;
        end
        if (st.dbg_s2 && !st.debug_control[0]) begin
            active = 1'b0;
        end

        evt_rise = st.evt_s2 && !st.evt_prev && st.event_control[0];

        // register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                adcrb_pkg::OFS_CONTROL_A: next_st.control_a = i_bus.wdata & adcrb_pkg::MSK_CONTROL_A;
                adcrb_pkg::OFS_CONTROL_B: next_st.control_b = i_bus.wdata & adcrb_pkg::MSK_CONTROL_B;
                adcrb_pkg::OFS_CONTROL_C: next_st.control_c = i_bus.wdata & adcrb_pkg::MSK_CONTROL_C;
                adcrb_pkg::OFS_CONTROL_D: next_st.control_d = i_bus.wdata;
                adcrb_pkg::OFS_CONTROL_E: next_st.control_e = i_bus.wdata & adcrb_pkg::MSK_CONTROL_E;
                adcrb_pkg::OFS_SAMPLE_LEN: begin
                    next_st.sample_length_ctrl = i_bus.wdata & adcrb_pkg::MSK_FIVE_BIT;
                end
                adcrb_pkg::OFS_INPUT_SEL: next_st.input_select = i_bus.wdata & adcrb_pkg::MSK_FIVE_BIT;
                adcrb_pkg::OFS_COMMAND: kick = i_bus.wdata[0];
                adcrb_pkg::OFS_EVENT_CTRL: next_st.event_control = i_bus.wdata & adcrb_pkg::MSK_ONE_BIT;
                adcrb_pkg::OFS_IRQ_ENABLE: next_st.irq_enable = i_bus.wdata & adcrb_pkg::MSK_TWO_BIT;
                adcrb_pkg::OFS_IRQ_FLAGS: flag_clr = i_bus.wdata & adcrb_pkg::MSK_TWO_BIT;
                adcrb_pkg::OFS_DEBUG_CTRL: next_st.debug_control = i_bus.wdata & adcrb_pkg::MSK_ONE_BIT;
                adcrb_pkg::OFS_BYTE_LATCH: next_st.byte_latch = i_bus.wdata;
                // low byte parks in latch, high byte commits both
                adcrb_pkg::OFS_WIN_LOW: next_st.byte_latch = i_bus.wdata;
                adcrb_pkg::OFS_WIN_LOW + 5'h01: begin
                    next_st.window_low_threshold = {i_bus.wdata, st.byte_latch};
                end
                adcrb_pkg::OFS_WIN_HIGH: next_st.byte_latch = i_bus.wdata;
                adcrb_pkg::OFS_WIN_HIGH + 5'h01: begin
                    next_st.window_high_threshold = {i_bus.wdata, st.byte_latch};
                end
                adcrb_pkg::OFS_CALIBRATION: next_st.calibration = i_bus.wdata & adcrb_pkg::MSK_ONE_BIT;
                default: next_st.calibration = st.calibration;
            endcase
        end

        // register reads, data one cycle later
        if (i_bus.rd) begin
            case (i_bus.addr)
                adcrb_pkg::OFS_CONTROL_A: next_st.rd_data = st.control_a;
                adcrb_pkg::OFS_CONTROL_B: next_st.rd_data = st.control_b;
                adcrb_pkg::OFS_CONTROL_C: next_st.rd_data = st.control_c;
                adcrb_pkg::OFS_CONTROL_D: next_st.rd_data = st.control_d;
                adcrb_pkg::OFS_CONTROL_E: next_st.rd_data = st.control_e;
                adcrb_pkg::OFS_SAMPLE_LEN: next_st.rd_data = st.sample_length_ctrl;
                adcrb_pkg::OFS_INPUT_SEL: next_st.rd_data = st.input_select;
                adcrb_pkg::OFS_COMMAND: next_st.rd_data = {7'h00, st.start_conversion};
                adcrb_pkg::OFS_EVENT_CTRL: next_st.rd_data = st.event_control;
                adcrb_pkg::OFS_IRQ_ENABLE: next_st.rd_data = st.irq_enable;
                adcrb_pkg::OFS_IRQ_FLAGS: next_st.rd_data = st.irq_flags;
                adcrb_pkg::OFS_DEBUG_CTRL: next_st.rd_data = st.debug_control;
                adcrb_pkg::OFS_BYTE_LATCH: next_st.rd_data = st.byte_latch;
                adcrb_pkg::OFS_RESULT: begin
                    next_st.rd_data = st.conversion_result[7:0];
                    next_st.byte_latch = st.conversion_result[15:8];
                    flag_clr = adcrb_pkg::MSK_TWO_BIT;
                end
                adcrb_pkg::OFS_WIN_LOW: begin
                    next_st.rd_data = st.window_low_threshold[7:0];
                    next_st.byte_latch = st.window_low_threshold[15:8];
                end
                adcrb_pkg::OFS_WIN_HIGH: begin
                    next_st.rd_data = st.window_high_threshold[7:0];
                    next_st.byte_latch = st.window_high_threshold[15:8];
                end
                // high bytes come from the latch
                adcrb_pkg::OFS_RESULT + 5'h01: next_st.rd_data = st.byte_latch;
                adcrb_pkg::OFS_WIN_LOW + 5'h01: next_st.rd_data = st.byte_latch;
                adcrb_pkg::OFS_WIN_HIGH + 5'h01: next_st.rd_data = st.byte_latch;
                adcrb_pkg::OFS_CALIBRATION: next_st.rd_data = st.calibration;
                default: next_st.rd_data = 8'h00;
            endcase
        end

        // start bit set by software or event
        if (active && (kick || evt_rise)) begin
            next_st.start_conversion = 1'b1;
        end

        // conversion sequencer
        case (st.phase)
            adcrb_pkg::PH_IDLE: begin
                if (active && st.start_conversion) begin
                    next_st.start_pulse = 1'b1;
                    next_st.phase = adcrb_pkg::PH_WAIT;
                end
            end
            adcrb_pkg::PH_WAIT: begin
                if (i_core_done) begin
                    if (st.control_a[adcrb_pkg::POS_RESOLUTION]) begin
                        sample_val = {8'h00, i_core_sample[9:2]};
                    end else begin
                        sample_val = {6'h00, i_core_sample};
                    end
                    sum = st.acc + sample_val;
                    next_st.acc = sum;
                    next_st.acc_cnt = st.acc_cnt + 7'h01;
                    if (st.acc_cnt + 7'h01 >= adcrb_acc_total(st.control_b[2:0])) begin
                        next_st.conversion_result = sum;
                        next_st.acc = 16'h0000;
                        next_st.acc_cnt = 7'h00;
                        next_st.result_event = 1'b1;
                        flag_set[adcrb_pkg::POS_FLAG_READY] = 1'b1;
                        flag_set[adcrb_pkg::POS_FLAG_WINDOW] = adcrb_win_hit(
                            st.control_e[2:0], sum, st.window_low_threshold,
                            st.window_high_threshold);
                        // continuous relaunch, parked in idle while gated
                        if (st.control_a[adcrb_pkg::POS_CONTINUOUS]) begin
                            next_st.start_pulse = active;
                            if (!active) begin
                                next_st.phase = adcrb_pkg::PH_IDLE;
                            end
                        end else begin
                            next_st.start_conversion = 1'b0;
                            next_st.phase = adcrb_pkg::PH_IDLE;
                        end
                    end else begin
                        next_st.start_pulse = 1'b1;
                    end
                end
            end
            default: next_st.phase = adcrb_pkg::PH_IDLE;
        endcase

        if (!st.control_a[adcrb_pkg::POS_ENABLE]) begin
            next_st.phase = adcrb_pkg::PH_IDLE;
            next_st.start_conversion = 1'b0;
            next_st.start_pulse = 1'b0;
            next_st.acc = 16'h0000;
            next_st.acc_cnt = 7'h00;
        end

        // sticky flags, a set beats a clear
        next_st.irq_flags = (st.irq_flags & ~flag_clr) | flag_set;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_rd_data = st.rd_data;
    assign o_core_start = st.start_pulse;
    assign o_conv_clk = st.conv_clk;
    assign o_enabled = st.control_a[adcrb_pkg::POS_ENABLE];
    assign o_result_event = st.result_event;
    assign o_irq = |(st.irq_flags & st.irq_enable);

    assign o_core_cfg.reference_sel = st.control_c[adcrb_pkg::POS_REFERENCE +: 2];
    assign o_core_cfg.sample_cap_sel = st.control_c[adcrb_pkg::POS_SAMPLE_CAP];
    assign o_core_cfg.input_select = st.input_select[4:0];
    assign o_core_cfg.sample_len = st.sample_length_ctrl[4:0];
    assign o_core_cfg.delay_ctrl = st.control_d;
    assign o_core_cfg.clock_duty_trim = st.calibration[0];

endmodule
`default_nettype wire

//--- tb/adcrb_core_model.sv
// behavioural analog conversion core that answers start pulses
`timescale 1ns/1ps
`default_nettype none
module adcrb_core_model (
    input wire logic i_clk, // peripheral clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_start, // start pulse from the block
    input wire logic [3:0] i_delay, // wait before answering
    input wire logic [9:0] i_value, // sample to hand back
    output logic o_done, // one-cycle done strobe
    output logic [9:0] o_sample // sample, valid with done
);
    int cnt;
    logic busy;
    logic [9:0] last;
    ////////////////////////////////////////
    // one answer per start, sample line inverted while not valid
    // start and strobe
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        o_sample <= ~last;
        if (i_rst) begin
            busy <= 1'b0;
            last <= 10'h000;
        end else if (i_start) begin
            busy <= 1'b1;
            cnt <= i_delay;
        end else if (busy && cnt == 0) begin
            busy <= 1'b0;
            o_done <= 1'b1;
            o_sample <= i_value;
            last <= i_value;
        end else if (busy) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

//--- tb/adcrb_monitor.sv
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
`default_nettype none
module adcrb_monitor (
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire adcrb_pkg::adcrb_bus_req_s i_bus, // bus request
    input wire logic o_core_start, // core start
    input wire logic i_core_done, // core done
    input wire adcrb_pkg::adcrb_core_cfg_s o_core_cfg, // core settings
    input wire logic o_enabled, // enable bit of control A
    input wire logic o_result_event, // result event
    input wire logic o_irq // interrupt
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////
    // a register write to one offset
    sequence s_wr(logic [4:0] a);
        i_bus.wr && i_bus.addr == a;
    endsequence
    property p_reset_quiet;
        $past(i_sys_rst) |-> !o_enabled && !o_irq && !o_core_start;
    endproperty
    property p_start_pulse;
        o_core_start |=> !o_core_start;
    endproperty
    property p_no_start_off;
        !o_enabled && !$past(o_enabled) |-> !o_core_start;
    endproperty
    property p_event_done;
        o_result_event |-> $past(i_core_done);
    endproperty
    property p_enable_wr;
        s_wr(adcrb_pkg::OFS_CONTROL_A) |=> o_enabled == $past(i_bus.wdata[0]);
    endproperty
    property p_cfg_wr;
        s_wr(adcrb_pkg::OFS_CONTROL_C) |=> o_core_cfg.sample_cap_sel == $past(i_bus.wdata[6])
            && o_core_cfg.reference_sel == $past(i_bus.wdata[5:4]);
    endproperty
    property p_irq_wclr;
        s_wr(adcrb_pkg::OFS_IRQ_FLAGS) ##0 (i_bus.wdata[1:0] == 2'h3 && !i_core_done)
            |=> !o_irq;
    endproperty
    property p_irq_rclr;
        i_bus.rd && i_bus.addr == adcrb_pkg::OFS_RESULT && !i_core_done |=> !o_irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("not idle after reset");
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    a_no_start_off: assert property (p_no_start_off) else $error("start while off");
    a_event_done: assert property (p_event_done) else $error("result without done");
    a_enable_wr: assert property (p_enable_wr) else $error("enable not applied");
    a_cfg_wr: assert property (p_cfg_wr) else $error("core settings wrong");
    a_irq_wclr: assert property (p_irq_wclr) else $error("flags not cleared");
    a_irq_rclr: assert property (p_irq_rclr) else $error("result read kept flags");
endmodule
bind adcrb_top adcrb_monitor mon_u (.i_ref_clk, .i_sys_rst, .i_bus, .o_core_start,
    .i_core_done, .o_core_cfg, .o_enabled, .o_result_event, .o_irq);
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    adcrb_pkg::adcrb_bus_req_s bus = '0;
    adcrb_pkg::adcrb_core_cfg_s cfg;
    logic [7:0] rdd;
    logic cstart, cdone, cclk, en, rev, irq;
    logic ev = 1'b0;
    logic stby = 1'b0;
    logic [9:0] csmp;
    logic [9:0] smp = 10'h155;
    logic [3:0] dly = 4'h0;
    logic [15:0] lf = 16'h8C0F;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int q[$];
    logic [4:0] wofs [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
        5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h16};
    logic [7:0] wmsk [14] = '{8'h87, 8'h07, 8'h77, 8'hFF, 8'h07, 8'h1F, 8'h1F, 8'h00,
        8'h01, 8'h03, 8'h01, 8'hFF, 8'h00, 8'h01};
    always #10 clk = ~clk;
    adcrb_top dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rd_data(rdd),
        .o_core_start(cstart), .i_core_done(cdone), .i_core_sample(csmp), .o_core_cfg(cfg),
        .o_conv_clk(cclk), .o_enabled(en), .i_start_event(ev), .i_standby(stby),
        .i_debug_halt(1'b0), .o_result_event(rev), .o_irq(irq));
    adcrb_core_model core_u (.i_clk(clk), .i_rst(rst), .i_start(cstart), .i_delay(dly),
        .i_value(smp), .o_done(cdone), .o_sample(csmp));
    ////////////////////////////////////////
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // random source, sample log and hang guard
    always @(posedge clk) begin
        lf <= nx(lf);
        cyc <= cyc + 1;
        if (cdone) begin
            q.push_back(int'(csmp));
            smp <= lf[9:0];
            dly <= lf[13:10];
        end
        if (cyc == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rck(input string nm, input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk(nm, {8'h00, e}, {8'h00, rdd});
    endtask
    task automatic wev(input int lim, output bit got);
        got = 1'b0;
        for (int t = 0; t < lim && !got; t++) begin
            @(negedge clk);
            got = (rev === 1'b1);
        end
    endtask
    task automatic per(output int n);
        int r;
        logic pv;
        r = 0;
        n = 0;
        pv = cclk;
        for (int t = 0; t < 3000 && r < 3; t++) begin
            @(negedge clk);
            n++;
            if (cclk && !pv) begin
                r++;
                if (r < 3) n = 0;
            end
            pv = cclk;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        int s, n, lt, ht, m, c;
        bit got, win;
        logic [7:0] v;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // reset values, access masks and holes
        foreach (wofs[k]) begin
            v = lf[7:0];
            rck("reset", wofs[k], 8'h00);
            wr(wofs[k], v);
            rck("access", wofs[k], v & wmsk[k]);
        end
        wr(adcrb_pkg::OFS_CONTROL_A, 8'h01);
        // conversion clock, reference and capacitor for every code
        for (int p = 0; p < 8; p++) begin
            wr(adcrb_pkg::OFS_CONTROL_C, {1'b0, p[0], 2'(p % 3), 1'b0, 3'(p)});
            @(negedge clk);
            chk("cfg", {13'h0000, p[0], 2'(p % 3)}, {13'h0000, cfg.sample_cap_sel,
                cfg.reference_sel});
            per(n);
            chk("conv_clk", 16'(2 << p), 16'(n));
        end
        // single conversions over every count, both resolutions and window modes
        for (int i = 0; i < 16; i++) begin
            c = i % 8;
            m = i % 5;
            lt = int'(lf[15:5]);
            ht = lt + int'(lf[15:7]);
            wr(adcrb_pkg::OFS_CONTROL_A, {5'h00, i[3], 2'b01});
            wr(adcrb_pkg::OFS_CONTROL_B, 8'(c));
            wr(adcrb_pkg::OFS_CONTROL_E, 8'(m));
            wr(adcrb_pkg::OFS_WIN_LOW, lt[7:0]);
            wr(adcrb_pkg::OFS_WIN_LOW + 5'h01, lt[15:8]);
            wr(adcrb_pkg::OFS_WIN_HIGH, ht[7:0]);
            wr(adcrb_pkg::OFS_WIN_HIGH + 5'h01, ht[15:8]);
            wr(adcrb_pkg::OFS_IRQ_ENABLE, 8'(i % 4));
            q.delete();
            wr(adcrb_pkg::OFS_COMMAND, 8'h01);
            rck("busy", adcrb_pkg::OFS_COMMAND, 8'h01);
            chk("enabled", 16'h0001, {15'h0000, en});
            wev(3000, got);
            chk("done", 16'h0001, {15'h0000, got});
            n = (c == 0 || c == 7) ? 1 : 1 << c;
            chk("samples", 16'(n), 16'(q.size()));
            s = 0;
            for (int k = 0; k < n && k < q.size(); k++) s += i[3] ? q[k] >> 2 : q[k];
            win = m == 1 ? s < lt : m == 2 ? s > ht : m == 3 ? s > lt && s < ht
                : m == 4 ? s < lt || s > ht : 1'b0;
            rck("flags", adcrb_pkg::OFS_IRQ_FLAGS, {6'h00, win, 1'b1});
            chk("irq", 16'h0000, {15'h0000, irq ^ |(2'(i % 4) & {win, 1'b1})});
            wr(adcrb_pkg::OFS_IRQ_FLAGS, 8'h00);
            rck("flags_keep", adcrb_pkg::OFS_IRQ_FLAGS, {6'h00, win, 1'b1});
            rck("idle", adcrb_pkg::OFS_COMMAND, 8'h00);
            if (i % 2 == 1) begin
                wr(adcrb_pkg::OFS_IRQ_FLAGS, 8'h03);
                rck("flags_w1c", adcrb_pkg::OFS_IRQ_FLAGS, 8'h00);
            end
            rck("res_lo", adcrb_pkg::OFS_RESULT, s[7:0]);
            rck("res_hi", adcrb_pkg::OFS_RESULT + 5'h01, s[15:8]);
            rck("flags_rd", adcrb_pkg::OFS_IRQ_FLAGS, 8'h00);
            chk("irq_off", 16'h0000, {15'h0000, irq});
        end
        // continuous mode waits for software, then relaunches until disabled
        wr(adcrb_pkg::OFS_CONTROL_A, 8'h03);
        wev(40, got);
        chk("no_self_start", 16'h0000, {15'h0000, got});
        wr(adcrb_pkg::OFS_COMMAND, 8'h01);
        for (int j = 0; j < 3; j++) begin
            wev(3000, got);
            chk("relaunch", 16'h0001, {15'h0000, got});
        end
        wr(adcrb_pkg::OFS_CONTROL_A, 8'h00);
        repeat (3) @(posedge clk);
        wev(200, got);
        chk("disabled", 16'h0000, {15'h0000, got});
        chk("enabled_off", 16'h0000, {15'h0000, en});
        // standby gating, then start by event
        @(posedge clk);
        stby <= 1'b1;
        wr(adcrb_pkg::OFS_CONTROL_A, 8'h01);
        wr(adcrb_pkg::OFS_COMMAND, 8'h01);
        wev(60, got);
        chk("standby_stop", 16'h0000, {15'h0000, got});
        wr(adcrb_pkg::OFS_CONTROL_A, 8'h81);
        wr(adcrb_pkg::OFS_COMMAND, 8'h01);
        wev(3000, got);
        chk("standby_run", 16'h0001, {15'h0000, got});
        wr(adcrb_pkg::OFS_EVENT_CTRL, 8'h01);
        @(posedge clk);
        stby <= 1'b0;
        ev <= 1'b1;
        wev(3000, got);
        chk("event_start", 16'h0001, {15'h0000, got});
        @(posedge clk);
        ev <= 1'b0;
        wrap_up();
    end
endmodule
`default_nettype wire
